// ==== src/hia_pkg.sv ====
// Shared constants, types and helpers for the hub interrupt aggregator.
package hia_pkg;
    // ========================================================
    // Register map
    // ========================================================
    localparam int HIA_IDX_W = 8;
    localparam int HIA_REG_W = 8;
    localparam int HIA_BUS_W = 32;
    localparam logic [HIA_IDX_W-1:0] HIA_IDX_ENABLE = 8'h23;
    localparam logic [HIA_IDX_W-1:0] HIA_IDX_FLAG = 8'h24;
    localparam logic [HIA_IDX_W-1:0] HIA_IDX_EVENT = 8'h40;
    localparam logic [HIA_IDX_W-1:0] HIA_IDX_EVMASK = 8'h41;
    localparam logic [HIA_IDX_W-1:0] HIA_IDX_UNMAPPED = 8'hFF;
    // ========================================================
    // Field layout and reset values
    // ========================================================
    localparam int HIA_BIT_GLOBAL_EN = 7;
    localparam int HIA_BIT_SUMMARY = 7;
    localparam int HIA_BIT_TX = 4;
    localparam int HIA_BIT_RX1 = 1;
    localparam int HIA_BIT_RX0 = 0;
    localparam int HIA_NUM_SRC = 3;
    localparam logic [HIA_REG_W-1:0] HIA_ENABLE_WMASK = 8'h93;
    localparam logic [HIA_REG_W-1:0] HIA_SOURCE_MASK = 8'h13;
    localparam logic [HIA_REG_W-1:0] HIA_RESET_VAL = 8'h00;
    // ========================================================
    // Bus encodings
    // ========================================================
    localparam logic [2:0] HIA_HSIZE_WORD = 3'h2;
    localparam logic HIA_HRESP_OKAY = 1'h0;
    typedef enum logic [0:0] {HIA_PH_IDLE, HIA_PH_WRITE} hia_phase_t;
    // ========================================================
    // Helpers
    // ========================================================
    function automatic logic [HIA_IDX_W-1:0] hia_word_index(input logic [HIA_BUS_W-1:0] a);
        if (a[HIA_BUS_W-1:HIA_IDX_W+2] == '0 && a[1:0] == 2'h0) begin
            return a[HIA_IDX_W+1:2];
        end
        return HIA_IDX_UNMAPPED;
    endfunction : hia_word_index
    function automatic logic [HIA_REG_W-1:0] hia_place(input logic rx0, input logic rx1,
                                                       input logic tx);
        logic [HIA_REG_W-1:0] v;
        v = HIA_RESET_VAL;
        v[HIA_BIT_RX0] = rx0;
        v[HIA_BIT_RX1] = rx1;
        v[HIA_BIT_TX] = tx;
        return v;
    endfunction : hia_place
endpackage : hia_pkg

// ==== src/hia_sticky.sv ====
// Bank of sticky flags where a set beats a clear in the same cycle.
`timescale 1ns/10ps
module hia_sticky #(
    parameter int W = 3
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        q_next = (q_reg & ~clr_i) | set_i;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : hia_sticky

// ==== src/hia_ahb_port.sv ====
// AHB-Lite address and data phase tracking for the register file.
`timescale 1ns/10ps
module hia_ahb_port
    import hia_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [HIA_BUS_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    output logic rd_take_o,
    output logic [HIA_IDX_W-1:0] rd_idx_o,
    output logic wr_stb_o,
    output logic [HIA_IDX_W-1:0] wr_idx_o
);
    logic take;
    hia_phase_t phase_reg;
    hia_phase_t phase_next;
    logic [HIA_IDX_W-1:0] idx_reg;

    assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == HIA_HSIZE_WORD);

    always_comb begin
        phase_next = HIA_PH_IDLE;
        case (phase_reg)
            HIA_PH_IDLE, HIA_PH_WRITE: begin
                if (take && hwrite_i) begin
                    phase_next = HIA_PH_WRITE;
                end
            end
            default: begin
                phase_next = HIA_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            phase_reg <= HIA_PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            idx_reg <= HIA_IDX_UNMAPPED;
        end else if (take) begin
            idx_reg <= hia_word_index(haddr_i);
        end
    end

    assign rd_take_o = take && !hwrite_i;
    assign rd_idx_o = hia_word_index(haddr_i);
    assign wr_stb_o = (phase_reg == HIA_PH_WRITE);
    assign wr_idx_o = idx_reg;
endmodule : hia_ahb_port

// ==== src/hia_top.sv ====
// Hub interrupt aggregator with AHB-Lite register access.
//
// Overview of operation
// - Host interrupt only when global enable set.
// - Transmit source gated by its enable bit.
// - Receive port 1 gated by its enable.
// - Receive port 0 gated by its enable.
// - Summary flag set by any enabled pending source.
// - Summary flag ignores the global enable.
// - Transmit pending clears on its source read.
// - Port 1 pending clears on status reads.
// - Port 0 pending clears on status reads.
`timescale 1ns/10ps
module hia_top
    import hia_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [HIA_BUS_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [HIA_BUS_W-1:0] hwdata_i,
    input wire logic hready_i,
    output logic [HIA_BUS_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic rx_port0_event_i,
    input wire logic rx_port1_event_i,
    input wire logic tx_port_event_i,
    input wire logic rx_port0_status_read_i,
    input wire logic rx_port1_status_read_i,
    input wire logic tx_port_source_read_i,
    output logic host_irq_o,
    output logic evt_irq_o
);
    // ========================================================
    // Bus port
    // ========================================================
    logic rd_take;
    logic [HIA_IDX_W-1:0] rd_idx;
    logic wr_stb;
    logic [HIA_IDX_W-1:0] wr_idx;

    hia_ahb_port u_port (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .rd_take_o(rd_take),
        .rd_idx_o(rd_idx),
        .wr_stb_o(wr_stb),
        .wr_idx_o(wr_idx)
    );

    // ========================================================
    // Control registers
    // ========================================================
    logic [HIA_REG_W-1:0] irq_enable_reg;
    logic [HIA_REG_W-1:0] irq_event_mask_reg;
    logic [HIA_REG_W-1:0] wdata;

    assign wdata = hwdata_i[HIA_REG_W-1:0];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_enable_reg <= HIA_RESET_VAL;
        end else if (wr_stb && wr_idx == HIA_IDX_ENABLE) begin
            irq_enable_reg <= wdata & HIA_ENABLE_WMASK;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_event_mask_reg <= HIA_RESET_VAL;
        end else if (wr_stb && wr_idx == HIA_IDX_EVMASK) begin
            irq_event_mask_reg <= wdata & HIA_SOURCE_MASK;
        end
    end

    // ========================================================
    // Per-source pending flags
    // ========================================================
    logic [HIA_NUM_SRC-1:0] pend_set;
    logic [HIA_NUM_SRC-1:0] pend_clr;
    logic [HIA_NUM_SRC-1:0] pend;
    logic rx_port0_irq_pending;
    logic rx_port1_irq_pending;
    logic tx_port_irq_pending;

    assign pend_set = {tx_port_event_i, rx_port1_event_i, rx_port0_event_i};
    // Clears come from reads of the originating blocks' own status registers.
    assign pend_clr = {tx_port_source_read_i, rx_port1_status_read_i, rx_port0_status_read_i};

    hia_sticky #(
        .W(HIA_NUM_SRC)
    ) u_pending (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .set_i(pend_set),
        .clr_i(pend_clr),
        .q_o(pend)
    );

    assign rx_port0_irq_pending = pend[0];
    assign rx_port1_irq_pending = pend[1];
    assign tx_port_irq_pending = pend[2];

    // ========================================================
    // Summary flag
    // ========================================================
    logic rx_port0_irq_enable;
    logic rx_port1_irq_enable;
    logic tx_port_irq_enable;
    logic global_irq_enable;
    logic summary;
    logic [HIA_REG_W-1:0] flag_image;

    assign rx_port0_irq_enable = irq_enable_reg[HIA_BIT_RX0];
    assign rx_port1_irq_enable = irq_enable_reg[HIA_BIT_RX1];
    assign tx_port_irq_enable = irq_enable_reg[HIA_BIT_TX];
    assign global_irq_enable = irq_enable_reg[HIA_BIT_GLOBAL_EN];

    // The global enable is left out on purpose so software can poll.
    always_comb begin
        summary = (tx_port_irq_pending && tx_port_irq_enable)
            || (rx_port1_irq_pending && rx_port1_irq_enable)
            || (rx_port0_irq_pending && rx_port0_irq_enable);
    end

    always_comb begin
        flag_image = hia_place(rx_port0_irq_pending, rx_port1_irq_pending,
                               tx_port_irq_pending);
        flag_image[HIA_BIT_SUMMARY] = summary;
    end

    // ========================================================
    // Event status, cleared by reading it
    // ========================================================
    logic [HIA_REG_W-1:0] irq_event_reg;
    logic [HIA_REG_W-1:0] evt_set;
    logic [HIA_REG_W-1:0] evt_clr;
    logic evt_read;

    assign evt_set = hia_place(rx_port0_event_i, rx_port1_event_i, tx_port_event_i);
    assign evt_read = rd_take && (rd_idx == HIA_IDX_EVENT);
    assign evt_clr = evt_read ? HIA_SOURCE_MASK : HIA_RESET_VAL;

    hia_sticky #(
        .W(HIA_REG_W)
    ) u_events (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .set_i(evt_set),
        .clr_i(evt_clr),
        .q_o(irq_event_reg)
    );

    // ========================================================
    // Read data and bus response
    // ========================================================
    logic [HIA_BUS_W-1:0] hrdata_reg;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [HIA_REG_W-1:0] rd_mux;

    always_comb begin
        case (rd_idx)
            HIA_IDX_ENABLE: rd_mux = irq_enable_reg;
            HIA_IDX_FLAG: rd_mux = flag_image;
            HIA_IDX_EVENT: rd_mux = irq_event_reg;
            HIA_IDX_EVMASK: rd_mux = irq_event_mask_reg;
            default: rd_mux = HIA_RESET_VAL;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            hrdata_reg <= '0;
        end else if (rd_take) begin
            hrdata_reg <= {{(HIA_BUS_W-HIA_REG_W){1'h0}}, rd_mux};
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            hreadyout_reg <= 1'h1;
            hresp_reg <= HIA_HRESP_OKAY;
        end else begin
            hreadyout_reg <= 1'h1;
            hresp_reg <= HIA_HRESP_OKAY;
        end
    end

    assign hrdata_o = hrdata_reg;
    assign hreadyout_o = hreadyout_reg;
    assign hresp_o = hresp_reg;

    // ========================================================
    // Interrupt outputs
    // ========================================================
    logic host_irq_reg;
    logic evt_irq_reg;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            host_irq_reg <= 1'h0;
        end else begin
            host_irq_reg <= summary && global_irq_enable;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            evt_irq_reg <= 1'h0;
        end else begin
            evt_irq_reg <= |(irq_event_reg & irq_event_mask_reg);
        end
    end

    assign host_irq_o = host_irq_reg;
    assign evt_irq_o = evt_irq_reg;

    // ========================================================
    // Assertions
    // ========================================================
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_tx_clean_read;
        tx_port_source_read_i && !tx_port_event_i;
    endsequence

    sequence s_rx1_clean_read;
        rx_port1_status_read_i && !rx_port1_event_i;
    endsequence

    sequence s_rx0_clean_read;
        rx_port0_status_read_i && !rx_port0_event_i;
    endsequence

    sequence s_flag_read;
        rd_take && rd_idx == HIA_IDX_FLAG;
    endsequence

    sequence s_enable_write;
        wr_stb && wr_idx == HIA_IDX_ENABLE;
    endsequence

    a_host_needs_global: assert property (
        host_irq_o |-> $past(global_irq_enable))
        else $error("Host interrupt raised without global enable.");

    a_tx_gate_off: assert property (
        (!tx_port_irq_enable && !(rx_port1_irq_pending && rx_port1_irq_enable)
         && !(rx_port0_irq_pending && rx_port0_irq_enable)) |-> !summary)
        else $error("Disabled transmit source raised the summary.");

    a_rx1_gate_off: assert property (
        (!rx_port1_irq_enable && !(tx_port_irq_pending && tx_port_irq_enable)
         && !(rx_port0_irq_pending && rx_port0_irq_enable)) |-> !summary)
        else $error("Disabled port 1 raised the summary.");

    a_rx0_gate_off: assert property (
        (!rx_port0_irq_enable && !(tx_port_irq_pending && tx_port_irq_enable)
         && !(rx_port1_irq_pending && rx_port1_irq_enable)) |-> !summary)
        else $error("Disabled port 0 raised the summary.");

    a_summary_read: assert property (
        (s_flag_read and ((pend & {tx_port_irq_enable, rx_port1_irq_enable,
                                   rx_port0_irq_enable}) != '0))
        |=> hrdata_o[HIA_BIT_SUMMARY])
        else $error("Summary flag read back clear while a source is pending.");

    a_summary_no_global: assert property (
        (!global_irq_enable && tx_port_event_i && tx_port_irq_enable)
        ##1 (tx_port_irq_enable && !global_irq_enable) |-> summary && !host_irq_o)
        else $error("Summary flag depends on the global enable.");

    a_tx_clear_read: assert property (
        s_tx_clean_read |=> !tx_port_irq_pending)
        else $error("Transmit pending did not clear on its source read.");

    a_tx_set_wins: assert property (
        tx_port_event_i |=> tx_port_irq_pending)
        else $error("Transmit event lost.");

    a_rx1_clear_read: assert property (
        s_rx1_clean_read |=> !rx_port1_irq_pending)
        else $error("Port 1 pending did not clear on status reads.");

    a_rx1_hold: assert property (
        (rx_port1_irq_pending && !rx_port1_status_read_i) |=> rx_port1_irq_pending)
        else $error("Port 1 pending dropped without a status read.");

    a_rx0_clear_read: assert property (
        s_rx0_clean_read |=> !rx_port0_irq_pending)
        else $error("Port 0 pending did not clear on status reads.");

    a_rx0_set_wins: assert property (
        (rx_port0_event_i && rx_port0_status_read_i) |=> rx_port0_irq_pending)
        else $error("Port 0 event lost against a clear.");

    a_host_irq_track: assert property (
        ##1 (host_irq_o == ($past(summary) && $past(global_irq_enable))))
        else $error("Host interrupt does not follow summary and enable.");

    a_host_irq_drop: assert property (
        (global_irq_enable ##1 !global_irq_enable) |=> !host_irq_o)
        else $error("Host interrupt stayed up after global disable.");

    a_reserved_zero: assert property (
        ((irq_enable_reg & ~HIA_ENABLE_WMASK) == '0)
        && (hrdata_o[HIA_BUS_W-1:HIA_REG_W] == '0))
        else $error("Reserved bits not zero.");

    a_flag_layout: assert property (
        s_flag_read |=> (hrdata_o[HIA_REG_W-1:0] & ~(HIA_SOURCE_MASK
            | (HIA_REG_W'(1) << HIA_BIT_SUMMARY))) == '0)
        else $error("Reserved flag bits read non-zero.");

    a_enable_write: assert property (
        s_enable_write |=> irq_enable_reg == ($past(wdata) & HIA_ENABLE_WMASK))
        else $error("Enable write did not land with reserved bits dropped.");

    a_event_clear_read: assert property (
        (rd_take && rd_idx == HIA_IDX_EVENT && !rx_port0_event_i)
        |=> !irq_event_reg[HIA_BIT_RX0])
        else $error("Event status did not clear on read.");

    a_evt_irq_track: assert property (
        ##1 (evt_irq_o == (|($past(irq_event_reg) & $past(irq_event_mask_reg)))))
        else $error("Event interrupt does not follow status and mask.");

    a_bus_okay: assert property (
        hreadyout_o && hresp_o == HIA_HRESP_OKAY)
        else $error("Bus response not ready and okay.");
endmodule : hia_top

// ==== tb/hia_host_model.sv ====
// Host controller model that samples and counts the interrupt line.
`timescale 1ns/10ps
module hia_host_model (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic irq_i,
    output logic irq_seen_o,
    output logic [7:0] irq_count_o
);
    // ========================================
    // Line sampling
    // ========================================
    // The host sees the level one edge late, as a synchronised input.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_seen_o <= 1'h0;
        end else begin
            irq_seen_o <= irq_i;
        end
    end
    // Each rise of the line counts as one service request.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_count_o <= 8'h00;
        end else if (irq_i && !irq_seen_o) begin
            irq_count_o <= irq_count_o + 8'h01;
        end
    end
endmodule : hia_host_model

// ==== tb/hub_interrupt_aggregator_bench.sv ====
// Self-checking bench for the hub interrupt aggregator.
`timescale 1ns/10ps
module hub_interrupt_aggregator_bench
    import hia_pkg::*;
;
    logic clock_i, rst_i, hsel, hwrite, hreadyout, hresp, host_irq, evt_irq, seen;
    logic [1:0] htrans;
    logic [2:0] hsize, set_v, clr_v, pend, ev_m;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [7:0] en_m, cnt, idx_list [4];
    int err_count, total_checks, seed;

    hia_top uut (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .rx_port0_event_i(set_v[0]), .rx_port1_event_i(set_v[1]), .tx_port_event_i(set_v[2]),
        .rx_port0_status_read_i(clr_v[0]), .rx_port1_status_read_i(clr_v[1]),
        .tx_port_source_read_i(clr_v[2]), .host_irq_o(host_irq), .evt_irq_o(evt_irq));
    hia_host_model host (.clock_i(clock_i), .rst_i(rst_i), .irq_i(host_irq),
        .irq_seen_o(seen), .irq_count_o(cnt));

    // ========================================
    // Expectations
    // ========================================
    function automatic logic [7:0] place(input logic [2:0] v);
        return {3'h0, v[2], 2'h0, v[1], v[0]};
    endfunction : place
    function automatic logic [7:0] exp_flag();
        logic [7:0] p;
        p = place(pend);
        return {|(p & en_m & 8'h13), p[6:0]};
    endfunction : exp_flag

    // ========================================
    // Checking and bus tasks
    // ========================================
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clock_i);
        while (hreadyout !== 1'h1) begin
            if (n == 50) begin
                err_count++;
                $display("BAD hready expected 1 seen stall");
                results();
            end
            n++;
            @(posedge clock_i);
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock_i);
        hsel <= 1'h1;
        haddr <= {22'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'h1, idx, wd, d);
    endtask : wr
    task automatic pulse(input logic [2:0] s, input logic [2:0] c);
        @(posedge clock_i);
        set_v <= s;
        clr_v <= c;
        @(posedge clock_i);
        set_v <= 3'h0;
        clr_v <= 3'h0;
        pend = (pend & ~c) | s;
        ev_m = ev_m | s;
    endtask : pulse
    task automatic check_flag();
        logic [7:0] e;
        bus(1'h0, HIA_IDX_FLAG, 32'h00000000, r);
        e = exp_flag();
        chk("flag", r, {24'h000000, e});
        @(posedge clock_i);
        @(negedge clock_i);
        chk("host_irq", {31'h0, host_irq}, {31'h0, e[7] & en_m[7]});
        chk("host_seen", {31'h0, seen}, {31'h0, e[7] & en_m[7]});
    endtask : check_flag
    task automatic settle();
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle

    // ========================================
    // Clock and main sequence
    // ========================================
    initial begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        rst_i = 1'h1;
        hsel = 1'h0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = HIA_HSIZE_WORD;
        hwdata = 32'h00000000;
        set_v = 3'h0;
        clr_v = 3'h0;
        pend = 3'h0;
        ev_m = 3'h0;
        en_m = 8'h00;
        err_count = 0;
        total_checks = 0;
        idx_list = '{HIA_IDX_ENABLE, HIA_IDX_FLAG, HIA_IDX_EVENT, HIA_IDX_EVMASK};
        seed = $urandom(32'hBA655631);
        repeat (2) @(posedge clock_i);
        rst_i <= 1'h0;
        @(negedge clock_i);
        chk("hreadyout", {31'h0, hreadyout}, 32'h00000001);
        chk("hresp", {31'h0, hresp}, {31'h0, HIA_HRESP_OKAY});
        chk("host_irq", {31'h0, host_irq}, 32'h00000000);
        foreach (idx_list[i]) begin
            bus(1'h0, idx_list[i], 32'h00000000, r);
            chk("reset value", r, 32'h00000000);
        end
        $display("done reset");
        wr(HIA_IDX_ENABLE, 32'hFFFFFFFF);
        bus(1'h0, HIA_IDX_ENABLE, 32'h00000000, r);
        chk("enable", r, 32'h00000093);
        wr(HIA_IDX_EVMASK, 32'hFFFFFFFF);
        bus(1'h0, HIA_IDX_EVMASK, 32'h00000000, r);
        chk("evmask", r, 32'h00000013);
        wr(HIA_IDX_EVMASK, 32'h00000000);
        wr(HIA_IDX_ENABLE, 32'h00000000);
        $display("done access");
        en_m = 8'h80;
        wr(HIA_IDX_ENABLE, {24'h000000, en_m});
        pulse(3'h7, 3'h0);
        check_flag();
        en_m = 8'h93;
        wr(HIA_IDX_ENABLE, {24'h000000, en_m});
        check_flag();
        for (int i = 0; i < 3; i++) begin
            pulse(3'h0, 3'h1 << i);
            check_flag();
        end
        chk("host count", {24'h0, cnt}, 32'h00000001);
        pulse(3'h7, 3'h7);
        check_flag();
        $display("done sources");
        repeat (40) begin
            en_m = 8'($urandom);
            wr(HIA_IDX_ENABLE, {24'h000000, en_m});
            en_m = en_m & 8'h93;
            pulse(3'($urandom), 3'($urandom));
            check_flag();
        end
        $display("done random");
        bus(1'h0, HIA_IDX_EVENT, 32'h00000000, r);
        chk("event", r, {24'h000000, place(ev_m)});
        ev_m = 3'h0;
        wr(HIA_IDX_EVMASK, 32'h00000013);
        pulse(3'h2, 3'h0);
        settle();
        chk("evt_irq raised", {31'h0, evt_irq}, 32'h00000001);
        wr(HIA_IDX_EVMASK, 32'h00000000);
        settle();
        chk("evt_irq masked", {31'h0, evt_irq}, 32'h00000000);
        wr(HIA_IDX_EVMASK, 32'h00000013);
        settle();
        chk("evt_irq unmasked", {31'h0, evt_irq}, 32'h00000001);
        bus(1'h0, HIA_IDX_EVENT, 32'h00000000, r);
        chk("event", r, 32'h00000002);
        settle();
        chk("evt_irq cleared", {31'h0, evt_irq}, 32'h00000000);
        bus(1'h0, HIA_IDX_EVENT, 32'h00000000, r);
        chk("event empty", r, 32'h00000000);
        $display("done event irq");
        wr(HIA_IDX_UNMAPPED, 32'hFFFFFFFF);
        bus(1'h0, HIA_IDX_UNMAPPED, 32'h00000000, r);
        chk("unmapped", r, 32'h00000000);
        bus(1'h0, HIA_IDX_ENABLE, 32'h00000000, r);
        chk("enable kept", r, {24'h000000, en_m});
        chk("hresp", {31'h0, hresp}, {31'h0, HIA_HRESP_OKAY});
        $display("done unmapped");
        pulse(3'h7, 3'h0);
        rst_i <= 1'h1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'h0;
        pend = 3'h0;
        en_m = 8'h00;
        @(negedge clock_i);
        chk("host_irq reset", {31'h0, host_irq}, 32'h00000000);
        chk("evt_irq reset", {31'h0, evt_irq}, 32'h00000000);
        foreach (idx_list[i]) begin
            bus(1'h0, idx_list[i], 32'h00000000, r);
            chk("second reset value", r, 32'h00000000);
        end
        $display("done second reset");
        results();
    end
endmodule : hub_interrupt_aggregator_bench
